//--- rtl/ssrsm_capture.sv
// one receive channel's slot capture on the link clock
// assumes hit marks each bit of the chosen slot and last its final bit
`timescale 1ns/100ps
module ssrsm_capture (
  // link clock and reset
  input wire logic bclk,
  input wire logic lrst,
  // slot selection
  input wire logic en,
  input wire logic pick_second,
  input wire logic hit,
  input wire logic last,
  // serial data
  input wire logic din_first,
  input wire logic din_second,
  // captured word and its event toggle
  output logic [ssrsm_pkg::WORD_W-1:0] word,
  output logic tog
);

  // ==========================================================================
  // state
  typedef struct packed {
    logic [ssrsm_pkg::WORD_W-1:0] shift;
    logic [ssrsm_pkg::WORD_W-1:0] word;
    logic tog;
  } ssrsm_cap_t;

  ssrsm_cap_t s_reg;
  ssrsm_cap_t s_next;
  logic bit_in;

  always_comb begin
    s_next = s_reg;
    bit_in = pick_second ? din_second : din_first;
    if (hit) begin
      s_next.shift = {s_reg.shift[ssrsm_pkg::WORD_W-2:0], bit_in};
    end
    // a disabled channel raises no event, so nothing goes downstream
    if (last && en) begin
      s_next.word = {s_reg.shift[ssrsm_pkg::WORD_W-2:0], bit_in};
      s_next.tog = ~s_reg.tog;
    end
  end

  always_ff @(posedge bclk) begin
    if (lrst) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign word = s_reg.word;
  assign tog = s_reg.tog;

endmodule : ssrsm_capture

//--- rtl/ssrsm_pkg.sv
// constants for the secondary receive slot map: register map, fields, resets, frame sizes
// assumes 32-bit apb data, one register per aligned word, byte address = index * 4
package ssrsm_pkg;

  // ==========================================================================
  // register indices and byte addresses
  localparam logic [11:0] IDX_PICK = 12'h027;
  localparam logic [11:0] IDX_CH3 = 12'h02a;
  localparam logic [11:0] IDX_CH4 = 12'h02b;
  localparam logic [11:0] IDX_CH5 = 12'h02c;
  localparam logic [11:0] IDX_FMT = 12'h030;
  localparam logic [11:0] IDX_STAT = 12'h031;
  localparam logic [11:0] ADDR_PICK = {IDX_PICK[9:0], 2'b00};
  localparam logic [11:0] ADDR_CH3 = {IDX_CH3[9:0], 2'b00};
  localparam logic [11:0] ADDR_CH4 = {IDX_CH4[9:0], 2'b00};
  localparam logic [11:0] ADDR_CH5 = {IDX_CH5[9:0], 2'b00};
  localparam logic [11:0] ADDR_FMT = {IDX_FMT[9:0], 2'b00};
  localparam logic [11:0] ADDR_STAT = {IDX_STAT[9:0], 2'b00};

  // ==========================================================================
  // reset values
  localparam logic [7:0] RST_CH3 = 8'h02;
  localparam logic [7:0] RST_CH4 = 8'h03;
  localparam logic [7:0] RST_CH5 = 8'h04;
  localparam logic [7:0] RST_PICK = 8'h00;
  localparam logic [7:0] RST_FMT = 8'h00;

  // ==========================================================================
  // field positions and writable masks
  localparam int EN_BIT = 5;
  localparam int SRC_LSB = 5;
  localparam int SRC_MSB = 6;
  localparam int SLOT_MSB = 4;
  localparam int HALF_BIT = 4;
  localparam int PICK_CH3_BIT = 2;
  localparam int PICK_CH4_BIT = 3;
  localparam int PICK_CH5_BIT = 4;
  localparam int FMT_HALF_BIT = 0;
  localparam logic [7:0] MASK_CH34 = 8'h3f;
  localparam logic [7:0] MASK_CH5 = 8'h7f;
  localparam logic [7:0] MASK_PICK = 8'h1c;
  localparam logic [7:0] MASK_FMT = 8'h01;

  // channel 5 source codes
  localparam logic [1:0] SRC_OFF = 2'h0;
  localparam logic [1:0] SRC_PLAY = 2'h1;
  localparam logic [1:0] SRC_LOOP = 2'h2;

  // ==========================================================================
  // frame geometry: 32 slots of 32 bits
  localparam int WORD_W = 32;
  localparam int CNT_W = 10;
  localparam logic [4:0] LAST_BIT = 5'h1f;

endpackage : ssrsm_pkg

//--- rtl/ssrsm_top.sv
// secondary serial receive slot map for channels 3 to 5, apb register slave
// assumes frames arrive on link_bclk, msb first, 32-bit slots, config changed while idle
//
// The implementer's own choice: the APB register port.
`timescale 1ns/100ps
module ssrsm_top (
  // system clock and reset
  input wire logic clk,
  input wire logic srst,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // audio serial port link
  input wire logic link_bclk,
  input wire logic link_fsync,
  input wire logic serial_data_in_primary,
  input wire logic serial_data_in_secondary,
  // destinations
  output logic [31:0] play3_data,
  output logic play3_valid,
  output logic [31:0] play4_data,
  output logic play4_valid,
  output logic [31:0] play5_data,
  output logic play5_valid,
  output logic [31:0] rec1_loop_data,
  output logic rec1_loop_valid
);

  // ==========================================================================
  // system domain state
  typedef struct packed {
    // software registers
    logic [7:0] ch3;
    logic [7:0] ch4;
    logic [7:0] ch5;
    logic [7:0] pick;
    logic [7:0] fmt;
    logic [2:0] seen;
    logic [31:0] rdata;
    // capture toggles: two synchroniser flops, then one for the edge
    logic [2:0] tog_s1;
    logic [2:0] tog_s2;
    logic [2:0] tog_s3;

    // destination words and one-cycle pulses
    logic [31:0] p3;
    logic [31:0] p4;
    logic [31:0] p5;
    logic [31:0] lb;
    logic v3;
    logic v4;
    logic v5;
    logic vl;
  } ssrsm_sys_t;

  // link domain state
  typedef struct packed {
    // synchronisers from the system side
    logic rst_s1;
    logic rst_s2;
    logic [39:0] cfg_s1;
    logic [39:0] cfg_s2;

    // frame position
    logic fsync_d;
    logic [ssrsm_pkg::CNT_W-1:0] cnt;
    // set once the count has run out, so a frame without sync captures nothing
    logic over;
  } ssrsm_link_t;

  ssrsm_sys_t s_reg;
  ssrsm_sys_t s_next;
  ssrsm_link_t l_reg;
  ssrsm_link_t l_next;

  // capture lanes, one per channel
  logic [2:0][31:0] cap_word;
  logic [2:0] cap_tog;
  logic [2:0] hit;
  logic [2:0] last;
  logic [2:0] en_l;
  logic [2:0] pick_l;

  // system side decode
  logic [2:0] tog_edge;
  logic wr;
  logic rd_setup;
  logic mapped;
  logic [7:0] wbyte;
  logic [7:0] rbyte;

  // link side frame position
  logic [ssrsm_pkg::CNT_W-1:0] pos;
  logic frame_start;
  logic live;
  logic half_mode;
  logic [1:0] src5;

  // ==========================================================================
  // apb decode
  assign wr = psel && penable && pwrite;
  assign rd_setup = psel && !penable;
  assign wbyte = pstrb[0] ? pwdata[7:0] : 8'h00;

  always_comb begin
    mapped = 1'b1;
    rbyte = 8'h00;
    case (paddr)
      ssrsm_pkg::ADDR_CH3: rbyte = s_reg.ch3;
      ssrsm_pkg::ADDR_CH4: rbyte = s_reg.ch4;
      ssrsm_pkg::ADDR_CH5: rbyte = s_reg.ch5;
      ssrsm_pkg::ADDR_PICK: rbyte = s_reg.pick;
      ssrsm_pkg::ADDR_FMT: rbyte = s_reg.fmt;
      ssrsm_pkg::ADDR_STAT: rbyte = {5'h00, s_reg.seen};
      default: mapped = 1'b0;
    endcase
  end

  // registers answer at once: no wait states
  assign pready = 1'b1;
  assign pslverr = psel && penable && !mapped;

  // ==========================================================================
  // system domain next state
  // the word has stood for several cycles when its toggle edge arrives
  assign tog_edge = s_reg.tog_s2 ^ s_reg.tog_s3;
  assign src5 = s_reg.ch5[ssrsm_pkg::SRC_MSB:ssrsm_pkg::SRC_LSB];

  always_comb begin
    s_next = s_reg;
    s_next.tog_s1 = cap_tog;
    s_next.tog_s2 = s_reg.tog_s1;
    s_next.tog_s3 = s_reg.tog_s2;
    s_next.v3 = 1'b0;
    s_next.v4 = 1'b0;
    s_next.v5 = 1'b0;
    s_next.vl = 1'b0;
    if (rd_setup) begin
      s_next.rdata = {24'h000000, rbyte};
    end
    // reserved bits keep their reset value whatever is written
    if (wr && pstrb[0]) begin
      case (paddr)
        ssrsm_pkg::ADDR_CH3: s_next.ch3 = wbyte & ssrsm_pkg::MASK_CH34;
        ssrsm_pkg::ADDR_CH4: s_next.ch4 = wbyte & ssrsm_pkg::MASK_CH34;
        ssrsm_pkg::ADDR_CH5: s_next.ch5 = wbyte & ssrsm_pkg::MASK_CH5;
        ssrsm_pkg::ADDR_PICK: s_next.pick = wbyte & ssrsm_pkg::MASK_PICK;
        ssrsm_pkg::ADDR_FMT: s_next.fmt = wbyte & ssrsm_pkg::MASK_FMT;
        ssrsm_pkg::ADDR_STAT: s_next.seen = s_reg.seen & ~wbyte[2:0];
        default: s_next.ch3 = s_reg.ch3;
      endcase
    end
    // a new word sets its seen flag even when cleared in the same cycle
    s_next.seen = s_next.seen | tog_edge;
    // channel 3
    if (!s_reg.ch3[ssrsm_pkg::EN_BIT]) begin
      s_next.p3 = '0;
    end else if (tog_edge[0]) begin
      s_next.p3 = cap_word[0];
      s_next.v3 = 1'b1;
    end
    // channel 4
    if (!s_reg.ch4[ssrsm_pkg::EN_BIT]) begin
      s_next.p4 = '0;
    end else if (tog_edge[1]) begin
      s_next.p4 = cap_word[1];
      s_next.v4 = 1'b1;
    end
    // channel 5: code 3 acts as disabled
    if (src5 != ssrsm_pkg::SRC_PLAY) begin
      s_next.p5 = '0;
    end else if (tog_edge[2]) begin
      s_next.p5 = cap_word[2];
      s_next.v5 = 1'b1;
    end
    if (src5 != ssrsm_pkg::SRC_LOOP) begin
      s_next.lb = '0;
    end else if (tog_edge[2]) begin
      s_next.lb = cap_word[2];
      s_next.vl = 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      s_reg <= '0;
      s_reg.ch3 <= ssrsm_pkg::RST_CH3;
      s_reg.ch4 <= ssrsm_pkg::RST_CH4;
      s_reg.ch5 <= ssrsm_pkg::RST_CH5;
      s_reg.pick <= ssrsm_pkg::RST_PICK;
      s_reg.fmt <= ssrsm_pkg::RST_FMT;
    end else begin
      s_reg <= s_next;
    end
  end

  // ==========================================================================
  // link domain: frame position and slot match
  // tdm frames start on a rising sync, i2s/lj halves on either edge
  assign frame_start = half_mode ? (link_fsync != l_reg.fsync_d)
                                 : (link_fsync && !l_reg.fsync_d);
  assign pos = frame_start ? '0 : l_reg.cnt;
  assign half_mode = l_reg.cfg_s2[ssrsm_pkg::FMT_HALF_BIT];
  assign live = frame_start || !l_reg.over;

  // cfg_s2 layout: {ch5, ch4, ch3, pick, fmt}
  always_comb begin
    en_l[0] = l_reg.cfg_s2[16 + ssrsm_pkg::EN_BIT];
    en_l[1] = l_reg.cfg_s2[24 + ssrsm_pkg::EN_BIT];
    en_l[2] = l_reg.cfg_s2[32 + ssrsm_pkg::SRC_MSB] != l_reg.cfg_s2[32 + ssrsm_pkg::SRC_LSB];
    pick_l[0] = l_reg.cfg_s2[8 + ssrsm_pkg::PICK_CH3_BIT];
    pick_l[1] = l_reg.cfg_s2[8 + ssrsm_pkg::PICK_CH4_BIT];
    pick_l[2] = l_reg.cfg_s2[8 + ssrsm_pkg::PICK_CH5_BIT];
  end

  // slot match per channel
  for (genvar g = 0; g < 3; g++) begin : g_match
    logic [4:0] slot;
    assign slot = l_reg.cfg_s2[16 + 8 * g +: 5];
    always_comb begin
      if (half_mode) begin
        // upper field bit chooses the right half-frame
        hit[g] = live && (link_fsync == slot[ssrsm_pkg::HALF_BIT]) && !pos[9] &&
                 (pos[8:5] == slot[3:0]);
      end else begin
        hit[g] = live && (pos[9:5] == slot);
      end
      last[g] = hit[g] && (pos[4:0] == ssrsm_pkg::LAST_BIT);
    end

    ssrsm_capture u_cap (
      .bclk(link_bclk),
      .lrst(l_reg.rst_s2),
      .en(en_l[g]),
      .pick_second(pick_l[g]),
      .hit(hit[g]),
      .last(last[g]),
      .din_first(serial_data_in_primary),
      .din_second(serial_data_in_secondary),
      .word(cap_word[g]),
      .tog(cap_tog[g])
    );
  end

  always_comb begin
    l_next = l_reg;
    l_next.rst_s1 = srst;
    l_next.rst_s2 = l_reg.rst_s1;
    // config is quasi-static: software changes it only between frames
    l_next.cfg_s1 = {s_reg.ch5, s_reg.ch4, s_reg.ch3, s_reg.pick, s_reg.fmt};
    l_next.cfg_s2 = l_reg.cfg_s1;
    l_next.fsync_d = link_fsync;
    l_next.cnt = (&pos) ? pos : pos + 1'b1;
    l_next.over = !frame_start && (l_reg.over || (&pos));
  end

  // synchroniser flops take no reset so the reset itself can cross
  always_ff @(posedge link_bclk) begin
    l_reg.rst_s1 <= l_next.rst_s1;
    l_reg.rst_s2 <= l_next.rst_s2;
    l_reg.cfg_s1 <= l_next.cfg_s1;
    l_reg.cfg_s2 <= l_next.cfg_s2;
    if (l_reg.rst_s2) begin
      // follow the sync pin so its idle level is not taken for an edge
      l_reg.fsync_d <= link_fsync;
      l_reg.cnt <= '0;
      l_reg.over <= 1'b1;
    end else begin
      l_reg.fsync_d <= l_next.fsync_d;
      l_reg.cnt <= l_next.cnt;
      l_reg.over <= l_next.over;
    end
  end

  // ==========================================================================
  // outputs
  assign prdata = s_reg.rdata;
  assign play3_data = s_reg.p3;
  assign play3_valid = s_reg.v3;
  assign play4_data = s_reg.p4;
  assign play4_valid = s_reg.v4;
  assign play5_data = s_reg.p5;
  assign play5_valid = s_reg.v5;
  assign rec1_loop_data = s_reg.lb;
  assign rec1_loop_valid = s_reg.vl;

endmodule : ssrsm_top

//--- testbench/ssrsm_assertions.sv
// concurrent checks on the ports of the secondary receive slot map
// assumes it is bound to ssrsm_top from the testbench top file
`timescale 1ns/100ps
module ssrsm_assertions (
  // clock and reset
  input wire logic clk,
  input wire logic srst,
  // apb
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  input wire logic [31:0] prdata,
  input wire logic pslverr,
  // destinations
  input wire logic [31:0] play3_data,
  input wire logic play3_valid,
  input wire logic play4_valid,
  input wire logic play5_valid,
  input wire logic [31:0] rec1_loop_data,
  input wire logic rec1_loop_valid
);
  logic hit;
  logic en3_reg;
  logic [5:0] off3_reg;

  assign hit = paddr inside {ssrsm_pkg::ADDR_PICK, ssrsm_pkg::ADDR_CH3, ssrsm_pkg::ADDR_CH4,
    ssrsm_pkg::ADDR_CH5, ssrsm_pkg::ADDR_FMT, ssrsm_pkg::ADDR_STAT};

  // channel 3 enable shadow and cycles since it was last on
  always_ff @(posedge clk) begin
    if (srst) begin
      en3_reg <= 1'b0;
    end else if (psel && penable && pwrite && pstrb[0] && paddr == ssrsm_pkg::ADDR_CH3) begin
      en3_reg <= pwdata[5];
    end
    if (srst || en3_reg) begin
      off3_reg <= 6'h00;
    end else if (off3_reg != 6'h3f) begin
      off3_reg <= off3_reg + 6'h01;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);

  // ==========================================================================
  // checks
  a_err_phase: assert property (pslverr |-> psel && penable)
    else $error("slave error outside access phase");
  a_unmapped_err: assert property (psel && penable && !hit |-> pslverr && prdata == 0)
    else $error("unmapped access not refused");
  a_mapped_ok: assert property (psel && penable && hit |-> !pslverr)
    else $error("mapped access refused");
  a_p3_pulse: assert property (play3_valid |=> !play3_valid)
    else $error("playback 3 valid longer than one cycle");
  a_p4_pulse: assert property (play4_valid |=> !play4_valid)
    else $error("playback 4 valid longer than one cycle");
  a_loop_pulse: assert property (rec1_loop_valid |=> !rec1_loop_valid)
    else $error("loopback valid longer than one cycle");
  a_ch5_one_dest: assert property (!(play5_valid && rec1_loop_valid))
    else $error("channel 5 sent to two destinations");
  a_rst_quiet: assert property (disable iff (1'b0)
    srst |=> !play3_valid && play3_data == 0 && rec1_loop_data == 0)
    else $error("outputs not cleared by reset");
  a_off3_quiet: assert property (off3_reg == 6'h3f |-> !play3_valid && play3_data == 0)
    else $error("disabled channel 3 still forwards");

  c_play3: cover property (play3_valid);
  c_loop: cover property (rec1_loop_valid);
  c_err: cover property (pslverr);
endmodule : ssrsm_assertions

//--- testbench/ssrsm_host_model.sv
// host audio processor driving frames into the secondary receive port
// assumes 32-bit slots msb first; link clock runs only in frames and in the idle ticks before them
`timescale 1ns/100ps
module ssrsm_host_model (
  // link toward the block
  output logic link_bclk,
  output logic link_fsync,
  output logic din_p,
  output logic din_s
);
  initial begin
    link_bclk = 1'b0;
    link_fsync = 1'b0;
    din_p = 1'b0;
    din_s = 1'b1;
  end

  // word carried by a slot; right i2s slots are numbered from 16
  function automatic logic [31:0] wv(input int ln, input int s);
    return {8'h5a ^ 8'(ln), 8'(s), ~8'(s), 8'h3c};
  endfunction

  task automatic tick(input logic fs, input logic dp, input logic ds);
    link_fsync = fs;
    din_p = dp;
    din_s = ds;
    // rising edges kept clear of the system clock edges
    #37 link_bclk = 1'b1;
    #40 link_bclk = 1'b0;
    #3;
  endtask

  // idle data toggles so a stale bit is never mistaken for a good one
  task automatic idle(input int n, input logic fs);
    repeat (n) tick(fs, ~din_p, ~din_s);
  endtask

  // tdm: nl slots, fsync pulse at slot 0; i2s: nl left slots, then nr right
  task automatic frame(input logic i2s, input int nl, input int nr);
    logic [31:0] w0;
    logic [31:0] w1;
    int s;
    idle(4, i2s);
    for (int p = 0; p < 32 * (nl + nr); p++) begin
      s = (i2s && p >= 32 * nl) ? 16 + p / 32 - nl : p / 32;
      w0 = wv(0, s);
      w1 = wv(1, s);
      tick(i2s ? (p >= 32 * nl) : (p == 0), w0[31 - p % 32], w1[31 - p % 32]);
    end
    din_p = ~din_p;
    din_s = ~din_s;
  endtask
endmodule : ssrsm_host_model

//--- testbench/testbench.sv
// self-checking bench for the secondary receive slot map
// assumes ssrsm_host_model drives the link and apb tasks act as master
`timescale 1ns/100ps
module testbench;
  logic clk, srst, psel, penable, pwrite, pready, pslverr, ev;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rv, d3, d4, d5, dl;
  logic [3:0] pstrb;
  logic v3, v4, v5, vl;
  wire logic bclk, fsync, dp, ds;
  logic [31:0] dd [4];
  logic [31:0] got [4];
  int nv [4] = '{0, 0, 0, 0};
  int n_errors = 0;
  int compares = 0;

  ssrsm_top uut (.clk(clk), .srst(srst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .link_bclk(bclk), .link_fsync(fsync), .serial_data_in_primary(dp),
    .serial_data_in_secondary(ds), .play3_data(d3), .play3_valid(v3), .play4_data(d4),
    .play4_valid(v4), .play5_data(d5), .play5_valid(v5), .rec1_loop_data(dl),
    .rec1_loop_valid(vl));
  ssrsm_host_model host (.link_bclk(bclk), .link_fsync(fsync), .din_p(dp), .din_s(ds));

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  // destination monitor: last word and pulse count per output
  assign dd = '{d3, d4, d5, dl};
  always @(posedge clk) begin
    for (int i = 0; i < 4; i++) begin
      if ({vl, v5, v4, v3} >> i & 4'h1) begin
        got[i] <= dd[i];
        nv[i] <= nv[i] + 1;
      end
    end
  end

  // ==========================================================================
  // shared tasks
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      n_errors++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    pstrb <= 4'h1;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    rv = prdata;
    ev = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rchk(input logic [11:0] a, input logic [31:0] exp, input logic eerr);
    apb(1'b0, a, 32'h0);
    chk(rv, exp);
    chk({31'h0, ev}, {31'h0, eerr});
  endtask

  task automatic cfg(input logic [7:0] f, input logic [7:0] pk, input logic [7:0] c3,
                     input logic [7:0] c4, input logic [7:0] c5);
    apb(1'b1, ssrsm_pkg::ADDR_FMT, {24'h0, f});
    apb(1'b1, ssrsm_pkg::ADDR_PICK, {24'h0, pk});
    apb(1'b1, ssrsm_pkg::ADDR_CH3, {24'h0, c3});
    apb(1'b1, ssrsm_pkg::ADDR_CH4, {24'h0, c4});
    apb(1'b1, ssrsm_pkg::ADDR_CH5, {24'h0, c5});
  endtask

  task automatic run(input logic i2s, input int nl, input int nr);
    nv = '{0, 0, 0, 0};
    got = '{32'h0, 32'h0, 32'h0, 32'h0};
    host.frame(i2s, nl, nr);
    repeat (20) @(posedge clk);
  endtask

  // ==========================================================================
  // scenarios
  task automatic t_regs;
    chk(d3, 32'h0);
    rchk(ssrsm_pkg::ADDR_CH3, 32'h02, 1'b0);
    rchk(ssrsm_pkg::ADDR_CH4, 32'h03, 1'b0);
    rchk(ssrsm_pkg::ADDR_CH5, 32'h04, 1'b0);
    rchk(ssrsm_pkg::ADDR_PICK, 32'h00, 1'b0);
    rchk(12'h0a4, 32'h00, 1'b1);
    apb(1'b1, ssrsm_pkg::ADDR_CH5, 32'h5f);
    rchk(ssrsm_pkg::ADDR_CH5, 32'h5f, 1'b0);
    apb(1'b1, ssrsm_pkg::ADDR_CH4, 32'h3f);
    rchk(ssrsm_pkg::ADDR_CH4, 32'h3f, 1'b0);
    $display("test regs done");
  endtask

  task automatic t_tdm;
    cfg(8'h00, 8'h08, 8'h20, 8'h3f, 8'h45);
    run(1'b0, 32, 0);
    chk(got[0], host.wv(0, 0));
    chk(got[1], host.wv(1, 31));
    chk(got[3], host.wv(0, 5));
    chk(32'(nv[0] + nv[1] + nv[3]), 32'd3);
    chk(32'(nv[2]), 32'd0);
    rchk(ssrsm_pkg::ADDR_STAT, 32'h07, 1'b0);
    $display("test tdm done");
  endtask

  task automatic t_i2s;
    cfg(8'h01, 8'h04, 8'h30, 8'h2f, 8'h31);
    run(1'b1, 16, 2);
    chk(got[0], host.wv(1, 16));
    chk(got[1], host.wv(0, 15));
    chk(got[2], host.wv(0, 17));
    chk(32'(nv[3]), 32'd0);
    $display("test i2s done");
  endtask

  task automatic t_off;
    cfg(8'h00, 8'h00, 8'h02, 8'h03, 8'h04);
    apb(1'b1, ssrsm_pkg::ADDR_STAT, 32'h07);
    run(1'b0, 6, 0);
    rchk(ssrsm_pkg::ADDR_STAT, 32'h00, 1'b0);
    chk(32'(nv[0] + nv[1] + nv[2] + nv[3]), 32'd0);
    chk(d3, 32'h0);
    chk(d5, 32'h0);
    chk(dl, 32'h0);
    $display("test off done");
  endtask

  task automatic end_of_test;
    $display("compares %0d errors %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // ==========================================================================
  // main sequence and watchdog
  initial begin
    srst = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h0;
    pwdata = 32'h0;
    pstrb = 4'h0;
    fork
      repeat (6) @(posedge clk);
      host.idle(4, 1'b0);
    join
    @(posedge clk);
    srst <= 1'b0;
    t_regs;
    t_tdm;
    t_i2s;
    t_off;
    end_of_test;
  end

  initial begin
    #400000;
    n_errors++;
    end_of_test;
  end
endmodule : testbench

bind ssrsm_top ssrsm_assertions chk (.clk(clk), .srst(srst), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
  .pslverr(pslverr), .play3_data(play3_data), .play3_valid(play3_valid),
  .play4_valid(play4_valid), .play5_valid(play5_valid), .rec1_loop_data(rec1_loop_data),
  .rec1_loop_valid(rec1_loop_valid));
